// >>> core/dhtw_pkg.sv
package dhtw_pkg;

	// register byte offsets, low eight address bits
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CFG = 8'h00;
	localparam logic [7:0] OFS_LMODE = 8'h04;
	localparam logic [7:0] OFS_HMODE = 8'h08;
	localparam logic [7:0] OFS_CTL = 8'h0C;
	localparam logic [7:0] OFS_IMR = 8'h18;
	localparam logic [7:0] OFS_RIS = 8'h1C;
	localparam logic [7:0] OFS_MIS = 8'h20;
	localparam logic [7:0] OFS_ICR = 8'h24;
	localparam logic [7:0] OFS_LILR = 8'h28;
	localparam logic [7:0] OFS_HILR = 8'h2C;
	localparam logic [7:0] OFS_LMATCH = 8'h30;
	localparam logic [7:0] OFS_HMATCH = 8'h34;
	localparam logic [7:0] OFS_LPR = 8'h38;
	localparam logic [7:0] OFS_HPR = 8'h3C;
	localparam logic [7:0] OFS_LCNT = 8'h48;
	localparam logic [7:0] OFS_HCNT = 8'h4C;

	// width configuration codes
	localparam logic [2:0] CFG_T32 = 3'h0;
	localparam logic [2:0] CFG_SEC = 3'h1;
	localparam logic [2:0] CFG_SPLIT = 3'h4;

	// mode field codes
	localparam logic [1:0] MODE_ONESHOT = 2'h1;
	localparam logic [1:0] MODE_PERIODIC = 2'h2;

	// control word bit positions
	localparam int CTL_LEN = 0;
	localparam int CTL_LSTALL = 1;
	localparam int CTL_SECEN = 4;
	localparam int CTL_LOTE = 5;
	localparam int CTL_HEN = 8;
	localparam int CTL_HSTALL = 9;
	localparam int CTL_HOTE = 13;

	// status / mask / clear bit positions
	localparam int ST_LTO = 0;
	localparam int ST_SEC = 3;
	localparam int ST_HTO = 8;
	localparam logic [15:0] ST_VALID = 16'h0109;

	// reset and load values
	localparam logic [15:0] CNT_RST = 16'hFFFF;
	localparam logic [15:0] ILR_RST = 16'hFFFF;
	localparam logic [7:0] PR_RST = 8'h00;
	localparam logic [31:0] SEC_FIRST = 32'h0000_0001;

	// seconds clock: pin rate divided down to one tick a second
	localparam int PIN_CLK_HZ = 32768;
	localparam int SECOND_HZ = 1;
	localparam int RTC_DIV_DFLT = PIN_CLK_HZ / SECOND_HZ;

	typedef struct packed {
		logic [1:0] ote;
		logic sec_en;
		logic [1:0] stall;
		logic [1:0] en;
	} dhtw_ctl_t;

	localparam dhtw_ctl_t CTL_RST = '0;

	function automatic dhtw_ctl_t ctl_from_word(input logic [31:0] w);
		dhtw_ctl_t c;
		c.en = {w[CTL_HEN], w[CTL_LEN]};
		c.stall = {w[CTL_HSTALL], w[CTL_LSTALL]};
		c.ote = {w[CTL_HOTE], w[CTL_LOTE]};
		c.sec_en = w[CTL_SECEN];
		return c;
	endfunction : ctl_from_word

	function automatic logic [31:0] ctl_to_word(input dhtw_ctl_t c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[CTL_LEN] = c.en[0];
		w[CTL_HEN] = c.en[1];
		w[CTL_LSTALL] = c.stall[0];
		w[CTL_HSTALL] = c.stall[1];
		w[CTL_LOTE] = c.ote[0];
		w[CTL_HOTE] = c.ote[1];
		w[CTL_SECEN] = c.sec_en;
		return w;
	endfunction : ctl_to_word

endpackage : dhtw_pkg

// >>> core/dhtw_timer.sv
`timescale 1ns/10ps
// Contract
// - two 16-bit halves, split or joined
// - reset: inactive, controls clear, counts/loads 0xFFFF
// - reset: both prescale registers zero
// - width 0 joined timer, 1 seconds counter
// - width 0x4 selects independent 16-bit halves
// - joined: low load write fills both halves
// - joined: low count read returns both halves
// - joined timer: low mode field alone decides
// - low enable starts joined down-count
// - zero reloads; one-shot stops, periodic continues
// - zero sets low timeout raw until cleared
// - unmasked raw timeout shows as masked
// - trigger out pulses one cycle at zero
// - load write while running loads next cycle
// - stall freezes count, release resumes
// - seconds counter counts up, starts at one
// - pin clock divided to one hertz tick
// - seconds match rolls to zero, keeps counting
// - match sets raw, masked if unmasked; clearable
// - seconds enable overrides both stall bits
module dhtw_timer #(
	parameter int unsigned RTC_DIV = dhtw_pkg::RTC_DIV_DFLT
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// seconds clock pin
	input wire logic capture_compare_pin_0,
	// one-cycle triggers at timeout
	output logic low_trigger_out,
	output logic high_trigger_out
);

	generate
		if (RTC_DIV < 2) begin : g_bad_div
			$error("RTC_DIV must be at least 2");
		end
	endgenerate

	localparam int DIV_W = $clog2(RTC_DIV);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(RTC_DIV - 1);

	// bus pipeline
	logic dph_wr_r;
	logic dph_rd_r;
	logic [dhtw_pkg::ADDR_W-1:0] dph_addr_r;
	logic hreadyout_r;
	logic [31:0] hrdata_r;
	logic hresp_r;
	logic [31:0] rd_val;

	// block state
	logic [2:0] cfg_r, cfg_nxt;
	logic [1:0][1:0] mode_r, mode_nxt;
	dhtw_pkg::dhtw_ctl_t ctl_r, ctl_nxt;
	logic [1:0][15:0] ilr_r, ilr_nxt;
	logic [1:0][15:0] cnt_r, cnt_nxt;
	logic [1:0][7:0] pr_r, pr_nxt;
	logic [31:0] lmatch_r, lmatch_nxt;
	logic [15:0] hmatch_r, hmatch_nxt;
	logic [15:0] imr_r, imr_nxt;
	logic [15:0] raw_r;
	logic [15:0] set_v;
	logic [1:0] trig_r, trig_nxt;
	logic pin_q_r;
	logic [DIV_W-1:0] div_r;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction : hit

	wire acc = hsel & htrans[1] & hready;
	wire is_t32 = (cfg_r == dhtw_pkg::CFG_T32);
	wire is_sec = (cfg_r == dhtw_pkg::CFG_SEC);
	wire is_split = (cfg_r == dhtw_pkg::CFG_SPLIT);
	wire [31:0] cnt32 = cnt_r;
	wire [31:0] ilr32 = ilr_r;
	wire [31:0] wd = hwdata;
	wire wr_cfg = dph_wr_r & hit(dph_addr_r, dhtw_pkg::OFS_CFG);
	wire wr_lmode = dph_wr_r & hit(dph_addr_r, dhtw_pkg::OFS_LMODE);
	wire wr_hmode = dph_wr_r & hit(dph_addr_r, dhtw_pkg::OFS_HMODE);
	wire wr_ctl = dph_wr_r & hit(dph_addr_r, dhtw_pkg::OFS_CTL);
	wire wr_imr = dph_wr_r & hit(dph_addr_r, dhtw_pkg::OFS_IMR);
	wire wr_icr = dph_wr_r & hit(dph_addr_r, dhtw_pkg::OFS_ICR);
	wire wr_lilr = dph_wr_r & hit(dph_addr_r, dhtw_pkg::OFS_LILR);
	wire wr_hilr = dph_wr_r & hit(dph_addr_r, dhtw_pkg::OFS_HILR);
	wire wr_lmatch = dph_wr_r & hit(dph_addr_r, dhtw_pkg::OFS_LMATCH);
	wire wr_hmatch = dph_wr_r & hit(dph_addr_r, dhtw_pkg::OFS_HMATCH);
	wire wr_lpr = dph_wr_r & hit(dph_addr_r, dhtw_pkg::OFS_LPR);
	wire wr_hpr = dph_wr_r & hit(dph_addr_r, dhtw_pkg::OFS_HPR);
	wire [15:0] clr_v = wr_icr ? (wd[15:0] & dhtw_pkg::ST_VALID) : 16'h0000;

	// seconds counter runs on the low enable; its own enable masks both stalls
	wire stalled = ctl_r.stall[0] | ctl_r.stall[1];
	wire sec_run = is_sec & ctl_r.en[0] & (ctl_r.sec_en | ~stalled);
	// only rising edges count, so the pin's duty cycle does not matter
	wire pin_rise = capture_compare_pin_0 & ~pin_q_r;
	wire sec_tick = sec_run & pin_rise & (div_r == DIV_LAST);

	// ---------------- bus slave ----------------
	// reads take one wait state so a read right after a write sees the new value
	// a write commits at the end of its data phase, once hwdata stands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_wr_r <= 1'b0;
			dph_rd_r <= 1'b0;
			dph_addr_r <= 8'h00;
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
		end else begin
			dph_wr_r <= acc & hwrite;
			dph_rd_r <= acc & ~hwrite;
			if (acc) begin
				dph_addr_r <= haddr[7:0];
			end
			hreadyout_r <= ~(acc & ~hwrite);
			hresp_r <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= 32'h0000_0000;
		end else if (dph_rd_r) begin
			hrdata_r <= rd_val;
		end
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		if (hit(dph_addr_r, dhtw_pkg::OFS_CFG)) begin
			rd_val = {29'h0, cfg_r};
		end else if (hit(dph_addr_r, dhtw_pkg::OFS_LMODE)) begin
			rd_val = {30'h0, mode_r[0]};
		end else if (hit(dph_addr_r, dhtw_pkg::OFS_HMODE)) begin
			rd_val = {30'h0, mode_r[1]};
		end else if (hit(dph_addr_r, dhtw_pkg::OFS_CTL)) begin
			rd_val = dhtw_pkg::ctl_to_word(ctl_r);
		end else if (hit(dph_addr_r, dhtw_pkg::OFS_IMR)) begin
			rd_val = {16'h0, imr_r};
		end else if (hit(dph_addr_r, dhtw_pkg::OFS_RIS)) begin
			rd_val = {16'h0, raw_r};
		end else if (hit(dph_addr_r, dhtw_pkg::OFS_MIS)) begin
			rd_val = {16'h0, raw_r & imr_r};
		end else if (hit(dph_addr_r, dhtw_pkg::OFS_LILR)) begin
			rd_val = is_split ? {16'h0, ilr_r[0]} : ilr32;
		end else if (hit(dph_addr_r, dhtw_pkg::OFS_HILR)) begin
			rd_val = {16'h0, ilr_r[1]};
		end else if (hit(dph_addr_r, dhtw_pkg::OFS_LMATCH)) begin
			rd_val = lmatch_r;
		end else if (hit(dph_addr_r, dhtw_pkg::OFS_HMATCH)) begin
			rd_val = {16'h0, hmatch_r};
		end else if (hit(dph_addr_r, dhtw_pkg::OFS_LPR)) begin
			rd_val = {24'h0, pr_r[0]};
		end else if (hit(dph_addr_r, dhtw_pkg::OFS_HPR)) begin
			rd_val = {24'h0, pr_r[1]};
		end else if (hit(dph_addr_r, dhtw_pkg::OFS_LCNT)) begin
			rd_val = is_split ? {16'h0, cnt_r[0]} : cnt32;
		end else if (hit(dph_addr_r, dhtw_pkg::OFS_HCNT)) begin
			rd_val = {16'h0, cnt_r[1]};
		end
	end

	// ---------------- counting and register writes ----------------
	always_comb begin
		cfg_nxt = cfg_r;
		mode_nxt = mode_r;
		ctl_nxt = ctl_r;
		ilr_nxt = ilr_r;
		cnt_nxt = cnt_r;
		pr_nxt = pr_r;
		lmatch_nxt = lmatch_r;
		hmatch_nxt = hmatch_r;
		imr_nxt = imr_r;
		trig_nxt = 2'b00;
		set_v = 16'h0000;
		if (is_t32) begin
			// halves act as one down-counter; only the low mode field matters
			if (ctl_r.en[0] & ~ctl_r.stall[0]) begin
				if (cnt32 == 32'h0000_0000) begin
					cnt_nxt = ilr32;
					set_v[dhtw_pkg::ST_LTO] = 1'b1;
					trig_nxt[0] = ctl_r.ote[0];
					if (mode_r[0] != dhtw_pkg::MODE_PERIODIC) begin
						ctl_nxt.en[0] = 1'b0;
					end
				end else begin
					cnt_nxt = cnt32 - 32'h0000_0001;
				end
			end
		end else if (is_sec) begin
			if (sec_tick) begin
				if (cnt32 == lmatch_r) begin
					cnt_nxt = 32'h0000_0000;
					set_v[dhtw_pkg::ST_SEC] = 1'b1;
				end else begin
					cnt_nxt = cnt32 + 32'h0000_0001;
				end
			end
		end else if (is_split) begin
			// each half is its own 16-bit one-shot or periodic down-counter
			for (int h = 0; h < 2; h++) begin
				if (ctl_r.en[h] & ~ctl_r.stall[h]) begin
					if (cnt_r[h] == 16'h0000) begin
						cnt_nxt[h] = ilr_r[h];
						set_v[h == 0 ? dhtw_pkg::ST_LTO : dhtw_pkg::ST_HTO] = 1'b1;
						trig_nxt[h] = ctl_r.ote[h];
						if (mode_r[h] != dhtw_pkg::MODE_PERIODIC) begin
							ctl_nxt.en[h] = 1'b0;
						end
					end else begin
						cnt_nxt[h] = cnt_r[h] - 16'h0001;
					end
				end
			end
		end
		// width codes other than the three decoded leave both halves idle
		// software writes land after the counting so they take precedence
		if (wr_cfg) begin
			cfg_nxt = wd[2:0];
			// only entering seconds operation presets; rewriting it keeps the time
			if (wd[2:0] == dhtw_pkg::CFG_SEC && cfg_r != dhtw_pkg::CFG_SEC) begin
				cnt_nxt = dhtw_pkg::SEC_FIRST;
			end
		end
		if (wr_lmode) begin
			mode_nxt[0] = wd[1:0];
		end
		if (wr_hmode) begin
			mode_nxt[1] = wd[1:0];
		end
		if (wr_ctl) begin
			ctl_nxt = dhtw_pkg::ctl_from_word(wd);
		end
		if (wr_imr) begin
			imr_nxt = wd[15:0] & dhtw_pkg::ST_VALID;
		end
		// the seconds counter is never reloaded from the interval loads
		if (wr_lilr) begin
			ilr_nxt[0] = wd[15:0];
			if (!is_sec) begin
				cnt_nxt[0] = wd[15:0];
			end
			if (!is_split) begin
				ilr_nxt[1] = wd[31:16];
				if (!is_sec) begin
					cnt_nxt[1] = wd[31:16];
				end
			end
		end
		if (wr_hilr) begin
			ilr_nxt[1] = wd[15:0];
			if (!is_sec) begin
				cnt_nxt[1] = wd[15:0];
			end
		end
		if (wr_lmatch) begin
			lmatch_nxt = is_split ? {16'h0, wd[15:0]} : wd;
		end
		if (wr_hmatch) begin
			hmatch_nxt = wd[15:0];
		end
		if (wr_lpr) begin
			pr_nxt[0] = wd[7:0];
		end
		if (wr_hpr) begin
			pr_nxt[1] = wd[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_r <= dhtw_pkg::CFG_T32;
			mode_r <= '0;
			ctl_r <= dhtw_pkg::CTL_RST;
			ilr_r <= {dhtw_pkg::ILR_RST, dhtw_pkg::ILR_RST};
			cnt_r <= {dhtw_pkg::CNT_RST, dhtw_pkg::CNT_RST};
			pr_r <= {dhtw_pkg::PR_RST, dhtw_pkg::PR_RST};
			lmatch_r <= 32'h0000_0000;
			hmatch_r <= 16'h0000;
			imr_r <= 16'h0000;
			trig_r <= 2'b00;
		end else begin
			cfg_r <= cfg_nxt;
			mode_r <= mode_nxt;
			ctl_r <= ctl_nxt;
			ilr_r <= ilr_nxt;
			cnt_r <= cnt_nxt;
			pr_r <= pr_nxt;
			lmatch_r <= lmatch_nxt;
			hmatch_r <= hmatch_nxt;
			imr_r <= imr_nxt;
			trig_r <= trig_nxt;
		end
	end

	// a timeout in the same cycle as its clear stays set
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			raw_r <= 16'h0000;
		end else begin
			raw_r <= (raw_r & ~clr_v) | set_v;
		end
	end

	// pin is taken as synchronous; one flop gives its previous level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_q_r <= 1'b0;
			div_r <= '0;
		end else begin
			pin_q_r <= capture_compare_pin_0;
			if (!sec_run) begin
				div_r <= '0;
			end else if (pin_rise) begin
				div_r <= (div_r == DIV_LAST) ? '0 : div_r + DIV_W'(1);
			end
		end
	end

	// no access can fail, so the response stays okay
	assign hreadyout = hreadyout_r;
	assign hrdata = hrdata_r;
	assign hresp = hresp_r;
	assign low_trigger_out = trig_r[0];
	assign high_trigger_out = trig_r[1];

endmodule : dhtw_timer

// >>> dv/dhtw_pin_src.sv
`timescale 1ns/10ps
module dhtw_pin_src #(
	parameter int HALF_NS = 15259
) (
	// request
	input wire logic go,
	input wire logic [7:0] n_edges,
	// pin
	output logic pin,
	output logic busy
);
	// stands low between bursts so the bench knows every edge sent
	initial begin
		pin = 1'b0;
		busy = 1'b0;
		forever begin
			wait (go);
			busy = 1'b1;
			repeat (n_edges) begin
				#(HALF_NS) pin = 1'b1;
				#(HALF_NS) pin = 1'b0;
			end
			busy = 1'b0;
			wait (!go);
		end
	end
endmodule : dhtw_pin_src

// >>> dv/dhtw_timer_assertions.sv
`timescale 1ns/10ps
module dhtw_timer_chk #(
	parameter int unsigned RTC_DIV = dhtw_pkg::RTC_DIV_DFLT
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	// pin and triggers
	input wire logic capture_compare_pin_0,
	input wire logic low_trigger_out,
	input wire logic high_trigger_out
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire take = hsel && htrans[1] && hready;
	chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	chk_write_fast: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	chk_ready_short: assert property (!hreadyout |=> hreadyout)
		else $error("wait state too long");
	chk_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
		else $error("read data moved between reads");
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	chk_trig_low: assert property (low_trigger_out |=> !low_trigger_out)
		else $error("low trigger longer than a cycle");
	chk_trig_high: assert property (high_trigger_out |=> !high_trigger_out)
		else $error("high trigger longer than a cycle");
	chk_reset_idle: assert property ($rose(hresetn) |-> hreadyout && hrdata == 32'h0
		&& !low_trigger_out && !high_trigger_out)
		else $error("outputs not idle after reset");
endmodule : dhtw_timer_chk
bind dhtw_timer dhtw_timer_chk #(.RTC_DIV(RTC_DIV)) u_chk (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
	.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
	.capture_compare_pin_0(capture_compare_pin_0), .low_trigger_out(low_trigger_out),
	.high_trigger_out(high_trigger_out));

// >>> dv/tb.sv
`timescale 1ns/10ps
module tb;
	localparam int DIV = 4;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, pin, pin_busy, trig_l, trig_h;
	logic [31:0] hrdata;
	logic pin_go = 1'b0;
	logic [7:0] pin_n = 8'h00;
	logic ro_prev = 1'b1;
	logic [31:0] exp_q[$];
	logic [7:0] exp_a[$];
	int n_fail = 0;
	int samples_checked = 0;
	int n_tl = 0;
	int n_th = 0;
	always #50 hclk = ~hclk;
	dhtw_timer #(.RTC_DIV(DIV)) u_dhtw_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.capture_compare_pin_0(pin), .low_trigger_out(trig_l), .high_trigger_out(trig_h));
	dhtw_pin_src u_dhtw_pin_src (.go(pin_go), .n_edges(pin_n), .pin(pin), .busy(pin_busy));
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// outputs sampled mid-cycle, away from the launching edge
	always @(negedge hclk) begin
		if (hresetn && hreadyout === 1'b1 && ro_prev === 1'b0) begin
			check($sformatf("read %h", exp_a.pop_front()), hrdata, exp_q.pop_front());
		end
		ro_prev = hreadyout;
		if (trig_l === 1'b1) n_tl++;
		if (trig_h === 1'b1) n_th++;
	end
	task automatic bus_wait();
		do @(negedge hclk); while (hreadyout !== 1'b1);
		@(posedge hclk);
	endtask : bus_wait
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		bus_wait();
		htrans <= 2'h0;
		hwdata <= d;
		if (!w) begin
			exp_q.push_back(d);
			exp_a.push_back(a);
		end
		bus_wait();
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, e);
	endtask : rd
	task automatic pin_burst(input logic [7:0] n);
		pin_n <= n;
		pin_go <= 1'b1;
		@(posedge hclk);
		pin_go <= 1'b0;
		for (int i = 0; i < 20000 && pin_busy !== 1'b0; i++) @(posedge hclk);
		check("pin source idle", {31'h0, pin_busy}, 32'h0);
		repeat (8) @(posedge hclk);
	endtask : pin_burst
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run
	initial begin
		#(5_000_000);
		n_fail++;
		complete_run();
	end
	initial begin
		logic [31:0] v;
		logic [15:0] n;
		v = $urandom(32'h1e67);
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(dhtw_pkg::OFS_CFG, 32'h0);
		rd(dhtw_pkg::OFS_CTL, 32'h0);
		rd(dhtw_pkg::OFS_LCNT, {dhtw_pkg::CNT_RST, dhtw_pkg::CNT_RST});
		rd(dhtw_pkg::OFS_HILR, {16'h0000, dhtw_pkg::ILR_RST});
		rd(dhtw_pkg::OFS_LPR, {24'h0, dhtw_pkg::PR_RST});
		rd(dhtw_pkg::OFS_HPR, {24'h0, dhtw_pkg::PR_RST});
		rd(dhtw_pkg::OFS_RIS, 32'h0);
		rd(8'h40, 32'h0);
		$display("reset values done");
		v = $urandom();
		wr(dhtw_pkg::OFS_LILR, v);
		rd(dhtw_pkg::OFS_HILR, {16'h0000, v[31:16]});
		rd(dhtw_pkg::OFS_LCNT, v);
		$display("load pairing done");
		n = 16'($urandom_range(10, 3));
		wr(dhtw_pkg::OFS_IMR, 32'h1);
		wr(dhtw_pkg::OFS_LMODE, {30'h0, dhtw_pkg::MODE_ONESHOT});
		wr(dhtw_pkg::OFS_HMODE, {30'h0, dhtw_pkg::MODE_PERIODIC});
		wr(dhtw_pkg::OFS_LILR, {16'h0000, n});
		wr(dhtw_pkg::OFS_CTL, 32'h21);
		repeat (40) @(posedge hclk);
		rd(dhtw_pkg::OFS_CTL, 32'h20);
		rd(dhtw_pkg::OFS_LCNT, {16'h0000, n});
		rd(dhtw_pkg::OFS_RIS, 32'h1);
		rd(dhtw_pkg::OFS_MIS, 32'h1);
		check("low trigger pulses", 32'(n_tl), 32'h1);
		wr(dhtw_pkg::OFS_ICR, 32'h0);
		rd(dhtw_pkg::OFS_RIS, 32'h1);
		wr(dhtw_pkg::OFS_ICR, 32'h1);
		rd(dhtw_pkg::OFS_MIS, 32'h0);
		$display("one-shot done");
		wr(dhtw_pkg::OFS_IMR, 32'h0);
		wr(dhtw_pkg::OFS_LMODE, {30'h0, dhtw_pkg::MODE_PERIODIC});
		wr(dhtw_pkg::OFS_LILR, 32'h100);
		wr(dhtw_pkg::OFS_CTL, 32'h3);
		repeat (300) @(posedge hclk);
		rd(dhtw_pkg::OFS_LCNT, 32'h100);
		rd(dhtw_pkg::OFS_RIS, 32'h0);
		wr(dhtw_pkg::OFS_CTL, 32'h1);
		repeat (600) @(posedge hclk);
		rd(dhtw_pkg::OFS_RIS, 32'h1);
		rd(dhtw_pkg::OFS_CTL, 32'h1);
		rd(dhtw_pkg::OFS_MIS, 32'h0);
		// load while running: two counts pass before the stall write commits
		v = $urandom() | 32'h0000_0100;
		wr(dhtw_pkg::OFS_LILR, v);
		wr(dhtw_pkg::OFS_CTL, 32'h3);
		rd(dhtw_pkg::OFS_LCNT, v - 32'h0000_0002);
		wr(dhtw_pkg::OFS_CTL, 32'h0);
		$display("stall and periodic done");
		wr(dhtw_pkg::OFS_ICR, 32'h109);
		wr(dhtw_pkg::OFS_CFG, {29'h0, dhtw_pkg::CFG_SPLIT});
		wr(dhtw_pkg::OFS_HMODE, {30'h0, dhtw_pkg::MODE_ONESHOT});
		wr(dhtw_pkg::OFS_HILR, 32'h5);
		wr(dhtw_pkg::OFS_CTL, 32'h2100);
		repeat (30) @(posedge hclk);
		rd(dhtw_pkg::OFS_RIS, 32'h100);
		rd(dhtw_pkg::OFS_CTL, 32'h2000);
		rd(dhtw_pkg::OFS_HCNT, 32'h5);
		check("high trigger pulses", 32'(n_th), 32'h1);
		$display("split done");
		wr(dhtw_pkg::OFS_ICR, 32'h109);
		wr(dhtw_pkg::OFS_CFG, {29'h0, dhtw_pkg::CFG_SEC});
		rd(dhtw_pkg::OFS_CFG, {29'h0, dhtw_pkg::CFG_SEC});
		rd(dhtw_pkg::OFS_LCNT, dhtw_pkg::SEC_FIRST);
		wr(dhtw_pkg::OFS_LMATCH, 32'h3);
		wr(dhtw_pkg::OFS_IMR, 32'h8);
		// both stall bits set: seconds enable must override them
		wr(dhtw_pkg::OFS_CTL, 32'h213);
		pin_burst(8'(3 * DIV));
		rd(dhtw_pkg::OFS_LCNT, 32'h0);
		rd(dhtw_pkg::OFS_RIS, 32'h8);
		rd(dhtw_pkg::OFS_MIS, 32'h8);
		wr(dhtw_pkg::OFS_ICR, 32'h8);
		rd(dhtw_pkg::OFS_RIS, 32'h0);
		pin_burst(8'(DIV));
		rd(dhtw_pkg::OFS_LCNT, 32'h1);
		$display("seconds counter done");
		complete_run();
	end
endmodule : tb
